// ### fh_consts.vh
`ifndef FH_CONSTS_VH
`define FH_CONSTS_VH

// opcodes
`define FH_OP_NOP        8'h00
`define FH_OP_WRITE_ENABLE_CMD       8'h06
`define FH_OP_WRITE_DISABLE_CMD       8'h04
`define FH_OP_RDSR       8'h05
`define FH_OP_STATUS_WRITE_CMD       8'h01
`define FH_OP_READ       8'h03
`define FH_OP_FAST       8'h0b
`define FH_OP_DOR        8'h3b
`define FH_OP_DIOR       8'hbb
`define FH_OP_PP         8'h02
`define FH_OP_DPROG      8'ha2
`define FH_OP_OTP        8'h42
`define FH_OP_SE         8'h20
`define FH_OP_BE         8'hd8
`define FH_OP_CE         8'hc7
`define FH_OP_DP         8'hb9
`define FH_OP_RES        8'hab
`define FH_OP_RDID       8'h9f

// signature bytes, values arbitrary
`define FH_ID_HI         8'h5a
`define FH_ID_LO         8'h21
`define FH_ID_LEGACY     8'h3c

// geometry
`define FH_AW            24
`define FH_PAGE_BYTES    256
`define FH_SECT_MASK     24'hfff000
`define FH_BLK_MASK      24'hff0000
`define FH_BYTE_BITS     4'h8
`define FH_IDX_LAST      8'hff

// frame byte counts
`define FH_BC_OP         3'h1
`define FH_BC_ONE        3'h2
`define FH_BC_ADDR       3'h4
`define FH_BC_DUMMY      3'h5
`define FH_BC_RES        3'h4
`define FH_BC_MAX        3'h7

// status byte bit positions
`define FH_SR_BUSY       0
`define FH_SR_WEL        1
`define FH_SR_BP_LO      2
`define FH_SR_BP_HI      4
`define FH_SR_LOCK       7

// erase kinds
`define FH_ER_SECT       2'h0
`define FH_ER_BLK        2'h1
`define FH_ER_CHIP       2'h2

// internal cycle kinds
`define FH_K_PROG        3'h0
`define FH_K_OTP         3'h1
`define FH_K_STATUS_WRITE_CMD        3'h2
`define FH_K_SE          3'h3
`define FH_K_BE          3'h4
`define FH_K_CE          3'h5

// cycle times and clock rate
`define FH_CLK_MHZ       32'd200
`define FH_CLK_KHZ       32'd200000
`define FH_T_PP_US       32'd3000
`define FH_T_W_MS        32'd15
`define FH_T_SE_MS       32'd400
`define FH_T_BE_MS       32'd1000
`define FH_T_CE_MS       32'd20000

// pin sampler reset levels: sclk cs_n hold_n wp_n io1 io0
`define FH_SYNC_RST      6'h0c

`endif

// ### fh_sync.v
`timescale 1ns/1ps

// two-stage sampler for pins from outside the clock domain
module fh_sync #(
  parameter       W   = 1,
  parameter [W-1:0] RV = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // first stage feeds only the second
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= RV[i];
          sync_q <= RV[i];
        end else begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule // fh_sync

// ### fh_flash_ctrl.v
`timescale 1ns/1ps
`include "fh_consts.vh"
module fh_flash_ctrl #(
  parameter [31:0] PP_CYCLES = `FH_T_PP_US * `FH_CLK_MHZ,
  parameter [31:0] W_CYCLES  = `FH_T_W_MS * `FH_CLK_KHZ,
  parameter [31:0] SE_CYCLES = `FH_T_SE_MS * `FH_CLK_KHZ,
  parameter [31:0] BE_CYCLES = `FH_T_BE_MS * `FH_CLK_KHZ,
  parameter [31:0] CE_CYCLES = `FH_T_CE_MS * `FH_CLK_KHZ
) (
  input  wire               clk,
  input  wire               rst_n,
  input  wire               sclk,
  input  wire               cs_n,
  input  wire               hold_n,
  input  wire               wp_n,
  input  wire               io0_in,
  output reg                io0_out_q,
  output reg                io0_oe_n_q,
  input  wire               io1_in,
  output reg                io1_out_q,
  output reg                io1_oe_n_q,
  output reg  [`FH_AW-1:0]  arr_addr_q,
  input  wire [7:0]         arr_rdata,
  output reg  [7:0]         arr_wdata_q,
  output reg                arr_we_q,
  output reg                arr_erase_q,
  output reg  [1:0]         arr_erase_kind_q,
  output reg                busy_flag_q,
  output reg                write_enable_latch_q,
  output reg  [2:0]         protect_size_q,
  output reg                status_lock_q,
  output reg                deep_sleep_q,
  output reg                standby_q
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_PADDR = 2'h1;
  localparam [1:0] ST_PWR   = 2'h2;
  localparam [1:0] ST_WAIT  = 2'h3;

  wire [5:0]        sy;
  wire              sclk_s;
  wire              cs_s;
  wire              hold_s;
  wire              wp_s;
  wire              io1_s;
  wire              io0_s;
  reg               sclk_p_q;
  reg               cs_p_q;
  reg               armed_q;
  reg               hold_act_q;
  reg  [7:0]        op_q;
  reg  [7:0]        sh_q;
  reg  [3:0]        ibit_q;
  reg  [2:0]        bcnt_q;
  reg  [`FH_AW-1:0] addr_q;
  reg  [7:0]        stat_in_q;
  reg  [255:0]      valid_q;
  reg  [7:0]        pbuf [0:`FH_PAGE_BYTES-1];
  reg               data_seen_q;
  reg  [7:0]        tx_q;
  reg  [2:0]        obit_q;
  reg               drv_q;
  reg               id_cnt_q;
  reg               go_q;
  reg  [2:0]        go_kind_q;
  reg               wen_q;
  reg               wdis_q;
  reg               dp_q;
  reg               wake_q;
  reg  [1:0]        st_q;
  reg  [7:0]        idx_q;
  reg  [15:0]       pg_q;
  reg  [31:0]       tmr_q;

  // pin sampling
  fh_sync #(
    .W  (6),
    .RV (`FH_SYNC_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sclk, cs_n, hold_n, wp_n, io1_in, io0_in}),
    .q     (sy)
  );
  assign {sclk_s, cs_s, hold_s, wp_s, io1_s, io0_s} = sy;

  // edge detection; clock edges gated by selection and hold, select rise gated by arming only, select fall not gated
  wire sel      = ~cs_s & armed_q;
  wire sck_rise = sclk_s & ~sclk_p_q & sel & ~hold_act_q;
  wire sck_fall = ~sclk_s & sclk_p_q & sel & ~hold_act_q;
  wire cs_fall  = cs_p_q & ~cs_s;
  wire cs_rise  = ~cs_p_q & cs_s & armed_q;

  // frame decode helpers
  reg       dual_in;
  reg       dual_out;
  reg       rd_op;
  reg [2:0] need;
  reg [7:0] nb;
  reg [3:0] ib;
  reg [7:0] src;
  reg       prog_op;

  always @* begin
    prog_op  = (op_q == `FH_OP_PP) || (op_q == `FH_OP_DPROG) || (op_q == `FH_OP_OTP);
    dual_in  = ((op_q == `FH_OP_DIOR) && (bcnt_q != 3'h0) && (bcnt_q < `FH_BC_DUMMY)) ||
               ((op_q == `FH_OP_DPROG) && (bcnt_q >= `FH_BC_ADDR));
    dual_out = (op_q == `FH_OP_DOR) || (op_q == `FH_OP_DIOR);
    rd_op    = 1'b1;
    case (op_q)
      `FH_OP_READ: need = `FH_BC_ADDR;
      `FH_OP_FAST: need = `FH_BC_DUMMY;
      `FH_OP_DOR:  need = `FH_BC_DUMMY;
      `FH_OP_DIOR: need = `FH_BC_DUMMY;
      `FH_OP_RDSR: need = `FH_BC_OP;
      `FH_OP_RDID: need = `FH_BC_OP;
      `FH_OP_RES:  need = `FH_BC_RES;
      default: begin
        need  = `FH_BC_MAX;
        rd_op = 1'b0;
      end
    endcase
    // msb first shifting
    nb = dual_in ? {sh_q[5:0], io1_s, io0_s} : {sh_q[6:0], io0_s};
    ib = ibit_q + (dual_in ? 4'h2 : 4'h1);
    case (op_q)
      `FH_OP_RDSR: src = {status_lock_q, 2'h0, protect_size_q, write_enable_latch_q, busy_flag_q};
      `FH_OP_RDID: src = id_cnt_q ? `FH_ID_LO : `FH_ID_HI;
      `FH_OP_RES:  src = `FH_ID_LEGACY;
      default:     src = arr_rdata;
    endcase
  end

  wire rx_en   = sck_rise & ~(rd_op & (bcnt_q >= need));
  wire tx_en   = sck_fall & rd_op & (bcnt_q >= need);
  wire byte_ok = rx_en & (ib == `FH_BYTE_BITS);
  wire pb_we   = byte_ok & (bcnt_q >= `FH_BC_ADDR) &
                 ((op_q == `FH_OP_PP) || (op_q == `FH_OP_DPROG));

  // page buffer storage
  always @(posedge clk) begin
    if (pb_we) begin
      pbuf[addr_q[7:0]] <= nb;
    end
  end

  // pin history, arming and hold tracking
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_p_q   <= 1'b0;
      cs_p_q     <= 1'b0;
      armed_q    <= 1'b0;
      hold_act_q <= 1'b0;
    end else begin
      sclk_p_q <= sclk_s;
      cs_p_q   <= cs_s;
      if (cs_fall) begin
        armed_q <= 1'b1;
      end
      if (cs_s) begin
        hold_act_q <= 1'b0;
      end else if (!sclk_s) begin
        hold_act_q <= ~hold_s;
      end
    end
  end

  // serial frame: capture, transmit, command issue at deselect
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q        <= `FH_OP_NOP;
      sh_q        <= 8'h00;
      ibit_q      <= 4'h0;
      bcnt_q      <= 3'h0;
      addr_q      <= {`FH_AW{1'b0}};
      stat_in_q   <= 8'h00;
      valid_q     <= {256{1'b0}};
      data_seen_q <= 1'b0;
      tx_q        <= 8'h00;
      obit_q      <= 3'h0;
      drv_q       <= 1'b0;
      id_cnt_q    <= 1'b0;
      go_q        <= 1'b0;
      go_kind_q   <= `FH_K_PROG;
      wen_q       <= 1'b0;
      wdis_q      <= 1'b0;
      dp_q        <= 1'b0;
      wake_q      <= 1'b0;
      io1_out_q   <= 1'b0;
      io0_out_q   <= 1'b0;
    end else begin
      go_q   <= 1'b0;
      wen_q  <= 1'b0;
      wdis_q <= 1'b0;
      dp_q   <= 1'b0;
      wake_q <= 1'b0;
      if (cs_s) begin
        // deselected: frame state cleared
        op_q        <= `FH_OP_NOP;
        ibit_q      <= 4'h0;
        bcnt_q      <= 3'h0;
        obit_q      <= 3'h0;
        drv_q       <= 1'b0;
        id_cnt_q    <= 1'b0;
        data_seen_q <= 1'b0;
      end else begin
        if (rx_en) begin
          sh_q   <= nb;
          ibit_q <= byte_ok ? 4'h0 : ib;
        end
        if (byte_ok) begin
          if (bcnt_q != `FH_BC_MAX) begin
            bcnt_q <= bcnt_q + 3'h1;
          end
          if (bcnt_q == 3'h0) begin
            // opcode byte; filtered by deep sleep and busy
            if ((deep_sleep_q && nb != `FH_OP_RES) ||
                (busy_flag_q && nb != `FH_OP_RDSR)) begin
              op_q <= `FH_OP_NOP;
            end else begin
              op_q <= nb;
            end
            valid_q <= busy_flag_q ? valid_q : {256{1'b0}};
          end else if (bcnt_q < `FH_BC_ADDR) begin
            addr_q <= {addr_q[15:0], nb};
            if (bcnt_q == 3'h1) begin
              stat_in_q <= nb;
            end
          end else if (prog_op) begin
            // data wraps inside the addressed page
            valid_q[addr_q[7:0]] <= 1'b1;
            addr_q[7:0]          <= addr_q[7:0] + 8'h01;
            data_seen_q          <= 1'b1;
          end
        end
        if (tx_en) begin
          if (obit_q == 3'h0) begin
            drv_q    <= 1'b1;
            io1_out_q <= src[7];
            io0_out_q <= src[6];
            tx_q     <= dual_out ? {src[5:0], 2'h0} : {src[6:0], 1'b0};
            id_cnt_q <= ~id_cnt_q;
            addr_q   <= addr_q + {{(`FH_AW-1){1'b0}}, 1'b1};
          end else begin
            io1_out_q <= tx_q[7];
            io0_out_q <= tx_q[6];
            tx_q      <= dual_out ? {tx_q[5:0], 2'h0} : {tx_q[6:0], 1'b0};
          end
          obit_q <= obit_q + (dual_out ? 3'h2 : 3'h1);
        end
      end
      // command issue on deselect at a byte boundary
      if (cs_rise && ibit_q == 4'h0) begin
        case (op_q)
          `FH_OP_WRITE_ENABLE_CMD: wen_q  <= (bcnt_q == `FH_BC_OP);
          `FH_OP_WRITE_DISABLE_CMD: wdis_q <= (bcnt_q == `FH_BC_OP);
          `FH_OP_DP:   dp_q   <= (bcnt_q == `FH_BC_OP);
          `FH_OP_RES:  wake_q <= 1'b1;
          `FH_OP_STATUS_WRITE_CMD: begin
            go_q      <= write_enable_latch_q && (bcnt_q >= `FH_BC_ONE);
            go_kind_q <= `FH_K_STATUS_WRITE_CMD;
          end
          `FH_OP_PP, `FH_OP_DPROG: begin
            go_q      <= write_enable_latch_q && data_seen_q;
            go_kind_q <= `FH_K_PROG;
          end
          `FH_OP_OTP: begin
            go_q      <= write_enable_latch_q && data_seen_q;
            go_kind_q <= `FH_K_OTP;
          end
          `FH_OP_SE: begin
            go_q      <= write_enable_latch_q && (bcnt_q == `FH_BC_ADDR);
            go_kind_q <= `FH_K_SE;
          end
          `FH_OP_BE: begin
            go_q      <= write_enable_latch_q && (bcnt_q == `FH_BC_ADDR);
            go_kind_q <= `FH_K_BE;
          end
          `FH_OP_CE: begin
            go_q      <= write_enable_latch_q && (bcnt_q == `FH_BC_OP) &&
                         (protect_size_q == 3'h0);
            go_kind_q <= `FH_K_CE;
          end
          default: go_q <= 1'b0;
        endcase
      end
    end
  end

  // output enables: driven only while selected, unheld and sending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io1_oe_n_q <= 1'b1;
      io0_oe_n_q <= 1'b1;
    end else begin
      io1_oe_n_q <= ~(drv_q & ~cs_s & ~hold_act_q);
      io0_oe_n_q <= ~(drv_q & dual_out & ~cs_s & ~hold_act_q);
    end
  end

  // internal cycle engine, status bits and power state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q                 <= ST_IDLE;
      idx_q                <= 8'h00;
      pg_q                 <= 16'h0000;
      tmr_q                <= 32'h0;
      arr_addr_q           <= {`FH_AW{1'b0}};
      arr_wdata_q          <= 8'h00;
      arr_we_q             <= 1'b0;
      arr_erase_q          <= 1'b0;
      arr_erase_kind_q     <= `FH_ER_SECT;
      busy_flag_q          <= 1'b0;
      write_enable_latch_q <= 1'b0;
      protect_size_q       <= 3'h0;
      status_lock_q        <= 1'b0;
      deep_sleep_q         <= 1'b0;
      standby_q            <= 1'b0;
    end else begin
      arr_we_q    <= 1'b0;
      arr_erase_q <= 1'b0;
      standby_q   <= cs_s & ~busy_flag_q & ~deep_sleep_q & ~go_q & ~dp_q;
      if (dp_q) begin
        deep_sleep_q <= 1'b1;
      end else if (wake_q) begin
        deep_sleep_q <= 1'b0;
      end
      if (wdis_q) begin
        write_enable_latch_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          arr_addr_q <= addr_q;
          if (go_q) begin
            busy_flag_q <= 1'b1;
            st_q        <= ST_WAIT;
            case (go_kind_q)
              `FH_K_PROG: begin
                pg_q  <= addr_q[23:8];
                idx_q <= 8'h00;
                st_q  <= ST_PADDR;
              end
              `FH_K_OTP: tmr_q <= PP_CYCLES;
              `FH_K_STATUS_WRITE_CMD: begin
                if (!(~wp_s && status_lock_q)) begin
                  protect_size_q <= stat_in_q[`FH_SR_BP_HI:`FH_SR_BP_LO];
                  status_lock_q  <= stat_in_q[`FH_SR_LOCK];
                end
                tmr_q <= W_CYCLES;
              end
              `FH_K_SE: begin
                arr_erase_q      <= 1'b1;
                arr_erase_kind_q <= `FH_ER_SECT;
                arr_addr_q       <= addr_q & `FH_SECT_MASK;
                tmr_q            <= SE_CYCLES;
              end
              `FH_K_BE: begin
                arr_erase_q      <= 1'b1;
                arr_erase_kind_q <= `FH_ER_BLK;
                arr_addr_q       <= addr_q & `FH_BLK_MASK;
                tmr_q            <= BE_CYCLES;
              end
              default: begin
                arr_erase_q      <= 1'b1;
                arr_erase_kind_q <= `FH_ER_CHIP;
                arr_addr_q       <= {`FH_AW{1'b0}};
                tmr_q            <= CE_CYCLES;
              end
            endcase
          end
        end
        ST_PADDR: begin
          arr_addr_q <= {pg_q, idx_q};
          st_q       <= ST_PWR;
        end
        ST_PWR: begin
          // read-modify-write can only clear bits
          arr_we_q    <= valid_q[idx_q];
          arr_wdata_q <= pbuf[idx_q] & arr_rdata;
          idx_q       <= idx_q + 8'h01;
          if (idx_q == `FH_IDX_LAST) begin
            tmr_q <= PP_CYCLES;
            st_q  <= ST_WAIT;
          end else begin
            st_q <= ST_PADDR;
          end
        end
        default: begin
          if (tmr_q == 32'h0) begin
            busy_flag_q          <= 1'b0;
            write_enable_latch_q <= 1'b0;
            st_q                 <= ST_IDLE;
          end else begin
            tmr_q <= tmr_q - 32'h1;
          end
        end
      endcase
      if (wen_q) begin
        write_enable_latch_q <= 1'b1;
      end
    end
  end

endmodule // fh_flash_ctrl

// ### fh_ctrl_props.sv
`timescale 1ns/1ps
`include "fh_consts.vh"
// pin and array strobe checks for the flash controller
module fh_ctrl_props (
  input wire        clk,
  input wire        rst_n,
  input wire        sclk,
  input wire        cs_n,
  input wire        hold_n,
  input wire        wp_n,
  input wire        io0_oe_n_q,
  input wire        io1_out_q,
  input wire        io1_oe_n_q,
  input wire [23:0] arr_addr_q,
  input wire        arr_we_q,
  input wire        arr_erase_q,
  input wire [1:0]  arr_erase_kind_q,
  input wire        busy_flag_q,
  input wire        write_enable_latch_q,
  input wire [2:0]  protect_size_q,
  input wire        status_lock_q,
  input wire        deep_sleep_q,
  input wire        standby_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // link pin rules
  property p_desel_float;
    cs_n [*6] |-> io0_oe_n_q && io1_oe_n_q;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("pin driven while deselected");
  property p_hold_float;
    (!hold_n && !sclk) [*8] |-> ##2 (io0_oe_n_q && io1_oe_n_q);
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("pin driven during hold");
  property p_out_fall;
    (!cs_n && !$past(cs_n, 4) && !io1_oe_n_q && $changed(io1_out_q)) |-> !$past(sclk, 2);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("output moved off a falling edge");

  // array operations only inside an enabled busy cycle, erase alignment, latch cleared after the cycle
  property p_erase_busy;
    arr_erase_q |-> busy_flag_q && write_enable_latch_q;
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase outside enabled cycle");
  property p_write_busy;
    arr_we_q |-> busy_flag_q && write_enable_latch_q;
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("write outside enabled cycle");
  property p_erase_align;
    arr_erase_q |-> (arr_erase_kind_q == `FH_ER_SECT && arr_addr_q[11:0] == 12'h000)
      || (arr_erase_kind_q == `FH_ER_BLK && arr_addr_q[15:0] == 16'h0000)
      || (arr_erase_kind_q == `FH_ER_CHIP && arr_addr_q == 24'h000000);
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("erase region misaligned");
  property p_wel_clear;
    $fell(busy_flag_q) |-> !write_enable_latch_q;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("enable latch kept after cycle");

  // power states and write-protect freeze
  property p_sleep_quiet;
    deep_sleep_q |-> !busy_flag_q && !arr_we_q && !arr_erase_q;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in deep sleep");
  property p_standby;
    standby_q |-> !busy_flag_q && !deep_sleep_q && $past(cs_n, 3);
  endproperty
  a_standby: assert property (p_standby) else $error("standby while busy or selected");
  property p_wp_freeze;
    (!wp_n) [*4] ##0 status_lock_q |=> $stable(protect_size_q);
  endproperty
  a_wp_freeze: assert property (p_wp_freeze) else $error("protect size moved while frozen");

  // main scenarios reached
  c_chip: cover property (arr_erase_q && arr_erase_kind_q == `FH_ER_CHIP);
  c_hold: cover property (!hold_n && !cs_n);
  c_sleep: cover property ($rose(deep_sleep_q));
endmodule // fh_ctrl_props

bind fh_flash_ctrl fh_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
  .hold_n(hold_n), .wp_n(wp_n), .io0_oe_n_q(io0_oe_n_q), .io1_out_q(io1_out_q),
  .io1_oe_n_q(io1_oe_n_q), .arr_addr_q(arr_addr_q), .arr_we_q(arr_we_q),
  .arr_erase_q(arr_erase_q), .arr_erase_kind_q(arr_erase_kind_q),
  .busy_flag_q(busy_flag_q), .write_enable_latch_q(write_enable_latch_q),
  .protect_size_q(protect_size_q), .status_lock_q(status_lock_q),
  .deep_sleep_q(deep_sleep_q), .standby_q(standby_q));

// ### fh_host_bfm.sv
`timescale 1ns/1ps
// host spi master; lines it releases toggle instead of holding
module fh_host_bfm (
  output reg  sclk,
  output reg  cs_n,
  output reg  hold_n,
  output reg  io0_o,
  output reg  io1_o,
  input  wire io0_i,
  input  wire io1_i
);
  reg cpol;
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    io0_o = 1'b0;
    io1_o = 1'b1;
  end
  // one clock: set on fall, sample on rise; md 0 single, 1 dual in, 2 dual out
  task bit2(input [1:0] tx, input [1:0] md, output [1:0] rx);
    begin
      sclk = 1'b0;
      io0_o = (md == 2'd2) ? ~io0_o : tx[0];
      io1_o = (md == 2'd1) ? tx[1] : ~io1_o;
      #80;
      sclk = 1'b1;
      rx = {io1_i, io0_i};
      #80;
    end
  endtask
  // one byte, msb first
  task xfer(input [7:0] tx, input [1:0] md, output [7:0] rx);
    reg [7:0] sh;
    reg [1:0] r;
    begin
      sh = tx;
      rx = 8'h00;
      repeat ((md == 2'd0) ? 8 : 4) begin
        bit2((md == 2'd0) ? {1'b0, sh[7]} : sh[7:6], md, r);
        sh = (md == 2'd0) ? {sh[6:0], 1'b0} : {sh[5:0], 2'b00};
        rx = (md == 2'd0) ? {rx[6:0], r[1]} : {rx[5:0], r};
      end
    end
  endtask
  // frame edges; clock idles at its polarity outside frames
  task start;
    begin
      sclk = cpol;
      #80;
      cs_n = 1'b0;
      #80;
    end
  endtask
  task stop;
    begin
      sclk = cpol;
      #80;
      cs_n = 1'b1;
      #240;
    end
  endtask
  // hold with clock low, then junk clocks and data that must be ignored
  task pause;
    begin
      sclk = 1'b0;
      #80;
      hold_n = 1'b0;
      repeat (3) begin
        #80;
        sclk = 1'b1;
        io0_o = ~io0_o;
        #80;
        sclk = 1'b0;
      end
      #80;
      hold_n = 1'b1;
      #80;
    end
  endtask
endmodule // fh_host_bfm

// ### tb_top.sv
`timescale 1ns/1ps
`include "fh_consts.vh"
// bench: host model, byte array and the flash controller
module tb_top;
  reg         clk, rst_n, wp_n;
  reg  [7:0]  mem [0:65535];
  reg  [7:0]  rb, ra;
  reg  [15:0] got;
  integer     bad_count, total_checks, k, j;
  wire        sclk, cs_n, hold_n, h_io0, h_io1, io0_out_q, io0_oe_n_q, io1_out_q, io1_oe_n_q;
  wire        arr_we_q, arr_erase_q, busy_flag_q, write_enable_latch_q, status_lock_q;
  wire        deep_sleep_q, standby_q;
  wire [23:0] arr_addr_q;
  wire [7:0]  arr_wdata_q;
  wire [1:0]  arr_erase_kind_q;
  wire [2:0]  protect_size_q;
  wire        io0 = io0_oe_n_q ? h_io0 : io0_out_q;
  wire        io1 = io1_oe_n_q ? h_io1 : io1_out_q;

  fh_flash_ctrl #(.PP_CYCLES(32'd20), .W_CYCLES(32'd20), .SE_CYCLES(32'd20),
    .BE_CYCLES(32'd20), .CE_CYCLES(32'd20)) uut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n), .io0_in(io0), .io0_out_q(io0_out_q),
    .io0_oe_n_q(io0_oe_n_q), .io1_in(io1), .io1_out_q(io1_out_q), .io1_oe_n_q(io1_oe_n_q),
    .arr_addr_q(arr_addr_q), .arr_rdata(mem[arr_addr_q[15:0]]), .arr_wdata_q(arr_wdata_q),
    .arr_we_q(arr_we_q), .arr_erase_q(arr_erase_q), .arr_erase_kind_q(arr_erase_kind_q),
    .busy_flag_q(busy_flag_q), .write_enable_latch_q(write_enable_latch_q),
    .protect_size_q(protect_size_q), .status_lock_q(status_lock_q),
    .deep_sleep_q(deep_sleep_q), .standby_q(standby_q));
  fh_host_bfm u_host (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .io0_o(h_io0),
    .io1_o(h_io1), .io0_i(io0), .io1_i(io1));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // array: byte writes, erase fills sector or whole model with ones
  always @(posedge clk) begin
    if (arr_we_q)
      mem[arr_addr_q[15:0]] <= arr_wdata_q;
    if (arr_erase_q)
      for (j = 0; j < 65536; j = j + 1)
        if (arr_erase_kind_q != `FH_ER_SECT || j[15:12] == arr_addr_q[15:12])
          mem[j] <= 8'hff;
  end

  task chk(input string w, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s expected %h seen %h", w, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // opcode, n argument bytes (last dn in mode md), then two reads in mode rm (3: none)
  task frame(input [7:0] op, input [47:0] arg, input integer n, input integer dn,
             input [1:0] md, input [1:0] rm);
    integer i;
    begin
      u_host.start;
      u_host.xfer(op, 2'd0, rb);
      for (i = n - 1; i >= 0; i = i - 1)
        u_host.xfer(arg[8*i +: 8], (i < dn) ? md : 2'd0, rb);
      for (i = 0; i < 2 && rm != 2'd3; i = i + 1) begin
        u_host.xfer(8'h00, rm, rb);
        got = {got[7:0], rb};
      end
      u_host.stop;
    end
  endtask
  task op1(input [7:0] op);
    frame(op, 48'h0, 0, 0, 2'd0, 2'd3);
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      got = 16'hffff;
      while (got[8+`FH_SR_BUSY] !== 1'b0 && n < 50) begin
        frame(`FH_OP_RDSR, 48'h0, 0, 0, 2'd0, 2'd0);
        n = n + 1;
      end
      if (n == 50) begin
        chk("busy wait", 16'h0, 16'h1);
        conclude;
      end
    end
  endtask

  task s_start;
    begin
      u_host.xfer(`FH_OP_WRITE_ENABLE_CMD, 2'd0, rb);
      u_host.stop;
      chk("wel no fall", 16'h0, write_enable_latch_q);
      op1(`FH_OP_WRITE_ENABLE_CMD);
      chk("wel set", 16'h1, write_enable_latch_q);
      op1(`FH_OP_WRITE_DISABLE_CMD);
      chk("wel cleared", 16'h0, write_enable_latch_q);
    end
  endtask
  task s_prog;
    begin
      op1(`FH_OP_WRITE_ENABLE_CMD);
      frame(`FH_OP_PP, {24'h0012fe, 24'h3c5aa5}, 6, 3, 2'd0, 2'd3);
      chk("standby busy", 16'h0, standby_q);
      frame(`FH_OP_RDSR, 48'h0, 0, 0, 2'd0, 2'd0);
      chk("status busy", 16'h03, got[15:8] & 8'h03);
      wait_idle;
      chk("wel after", 16'h0, got[8+`FH_SR_WEL]);
      frame(`FH_OP_READ, 48'h0012fe, 3, 0, 2'd0, 2'd0);
      chk("page bytes", 16'h3c5a, got);
      frame(`FH_OP_FAST, 48'h00120000, 4, 0, 2'd0, 2'd0);
      chk("page wrap", 16'ha5ff, got);
    end
  endtask
  task s_dual;
    begin
      op1(`FH_OP_WRITE_ENABLE_CMD);
      frame(`FH_OP_DPROG, {24'h0012fe, 8'h0f}, 4, 1, 2'd1, 2'd3);
      wait_idle;
      frame(`FH_OP_DOR, {24'h0012fe, 8'h00}, 4, 0, 2'd0, 2'd2);
      chk("dual out", 16'h0c5a, got);
      u_host.cpol = 1'b1;
      frame(`FH_OP_DIOR, {24'h0012fe, 8'h00}, 4, 4, 2'd1, 2'd2);
      chk("dual io idle high", 16'h0c5a, got);
      u_host.cpol = 1'b0;
    end
  endtask
  task s_erase;
    integer i;
    reg [7:0] op;
    begin
      frame(`FH_OP_SE, 48'h001234, 3, 0, 2'd0, 2'd3);
      frame(`FH_OP_RDSR, 48'h0, 0, 0, 2'd0, 2'd0);
      chk("erase no wel", 16'h00, got[15:8] & 8'h03);
      op1(`FH_OP_WRITE_ENABLE_CMD);
      u_host.start;
      u_host.xfer(`FH_OP_SE, 2'd0, rb);
      for (i = 0; i < 3; i = i + 1)
        u_host.xfer(8'h00, 2'd0, rb);
      u_host.bit2(2'b00, 2'd0, ra[1:0]);
      u_host.stop;
      frame(`FH_OP_RDSR, 48'h0, 0, 0, 2'd0, 2'd0);
      chk("erase odd count", 16'h02, got[15:8] & 8'h03);
      for (i = 0; i < 3; i = i + 1) begin
        op = (i == 0) ? `FH_OP_SE : (i == 1) ? `FH_OP_BE : `FH_OP_CE;
        mem[16'h1234] = 8'h00;
        mem[16'h2000] = 8'h00;
        op1(`FH_OP_WRITE_ENABLE_CMD);
        frame(op, 48'h001234, (i == 2) ? 0 : 3, 0, 2'd0, 2'd3);
        wait_idle;
        frame(`FH_OP_READ, 48'h001234, 3, 0, 2'd0, 2'd0);
        chk("erased", 16'hffff, got);
        frame(`FH_OP_READ, 48'h002000, 3, 0, 2'd0, 2'd0);
        chk("next sector", (i == 0) ? 16'h00ff : 16'hffff, got);
      end
    end
  endtask
  task s_sleep;
    begin
      op1(`FH_OP_DP);
      chk("sleep", 16'h1, deep_sleep_q);
      op1(`FH_OP_WRITE_ENABLE_CMD);
      chk("wel in sleep", 16'h0, write_enable_latch_q);
      frame(`FH_OP_RES, 48'h0, 3, 0, 2'd0, 2'd0);
      chk("legacy sig", `FH_ID_LEGACY, got[15:8]);
      chk("woken", 16'h0, deep_sleep_q);
      chk("standby", 16'h1, standby_q);
    end
  endtask
  task s_id_hold;
    begin
      u_host.start;
      u_host.xfer(`FH_OP_RDID, 2'd0, rb);
      u_host.pause;
      u_host.xfer(8'h00, 2'd0, ra);
      u_host.pause;
      u_host.xfer(8'h00, 2'd0, rb);
      u_host.stop;
      chk("id over hold", {`FH_ID_HI, `FH_ID_LO}, {ra, rb});
    end
  endtask
  task s_wp;
    begin
      op1(`FH_OP_WRITE_ENABLE_CMD);
      frame(`FH_OP_STATUS_WRITE_CMD, 48'h9c, 1, 0, 2'd0, 2'd3);
      wait_idle;
      @(posedge clk) #1 wp_n = 1'b0;
      op1(`FH_OP_WRITE_ENABLE_CMD);
      frame(`FH_OP_STATUS_WRITE_CMD, 48'h00, 1, 0, 2'd0, 2'd3);
      wait_idle;
      chk("frozen", 16'h7, protect_size_q);
      @(posedge clk) #1 wp_n = 1'b1;
      op1(`FH_OP_WRITE_ENABLE_CMD);
      frame(`FH_OP_STATUS_WRITE_CMD, 48'h00, 1, 0, 2'd0, 2'd3);
      wait_idle;
      chk("unfrozen", 16'h0, protect_size_q);
    end
  endtask

  // reset with select already low, then the scenarios
  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    got = 16'h0;
    for (k = 0; k < 65536; k = k + 1)
      mem[k] = 8'hff;
    #1 u_host.cs_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    s_start;
    s_prog;
    s_dual;
    s_erase;
    s_sleep;
    s_id_hold;
    s_wp;
    conclude;
  end
endmodule // tb_top
